// ---- dv/can_emergency_frame_builder_tb_top.sv ----
`timescale 1ns/10ps
module can_emergency_frame_builder_tb_top;
   import cef_pkg::*;
   logic        core_clk = 0, resetn = 0, evt_valid = 0, evt_gateway = 0, stall = 0, saw_full = 0;
   logic [6:0]  node_id = 7'h01;
   cef_kind_e   evt_kind = CEF_IN_HI;
   logic [7:0]  evt_module = 0, evt_chan = 0, evt_flags = 0, clear_mask = 0, exp_sum = 0;
   logic        evt_ready, tx_valid, tx_ready;
   logic [7:0]  fault_summary_flags;
   logic [10:0] tx_id;
   logic [3:0]  tx_dlc;
   logic [63:0] tx_data;
   logic [63:0] exp_q[$];
   int          fails = 0, n_tests = 0, cycles = 0, seed;
   logic [15:0] codes [16] = '{16'h2110, 16'h2130, 16'h2310, 16'h2323, 16'h2330, 16'h3003, 16'h3110, 16'h3120,
                               16'h3320, 16'h7000, 16'h707a, 16'h707d, 16'h707e, 16'h707f, 16'h8130, 16'h8140};

   always #5 core_clk = ~core_clk;

   can_emergency_frame_builder #(.QDEPTH(4)) dut (.core_clk(core_clk), .resetn(resetn), .node_id(node_id),
      .evt_valid(evt_valid), .evt_kind(evt_kind), .evt_module(evt_module), .evt_chan(evt_chan),
      .evt_flags(evt_flags), .evt_gateway(evt_gateway), .clear_mask(clear_mask), .evt_ready(evt_ready),
      .fault_summary_flags(fault_summary_flags), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
      .tx_dlc(tx_dlc), .tx_data(tx_data));
   cef_tx_sink sink (.core_clk(core_clk), .resetn(resetn), .stall(stall), .tx_valid(tx_valid),
      .tx_ready(tx_ready));

   function automatic logic [7:0] bit_of(cef_kind_e k);
      return k <= CEF_LOAD_DUMP ? 8'h02 : k <= CEF_FIELD_LO ? 8'h04 : k <= CEF_LIST_REM ? 8'h80 : 8'h10;
   endfunction : bit_of

   function automatic logic [63:0] frame_of(cef_kind_e k, logic [7:0] m, c, f, logic g, logic [7:0] s);
      logic [7:0]  b3, b4, b5;
      logic [15:0] cd;
      cd = codes[k];
      b3 = (g || k == CEF_SYS_HI || k >= CEF_GUARD) ? 8'h00 : m;
      b4 = (g || k >= CEF_LIST_ADAPT) ? 8'h00 : c;
      b5 = (k == CEF_MODULE) ? f : 8'h00;
      return {16'h0000, b5, b4, b3, s, cd[15:8], cd[7:0]};
   endfunction : frame_of

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   task automatic chk1(string what, logic exp, logic seen);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk1

   task automatic chk8(string what, logic [7:0] exp, logic [7:0] seen);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk8

   task automatic chk_frame(logic [78:0] exp, logic [78:0] seen);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch frame expected %h seen %h", exp, seen);
      end
   endtask : chk_frame

   // Caller stands just after a rising edge; valid stays up for back-to-back sends
   task automatic send_evt(cef_kind_e k, logic [7:0] m, c, f, logic g);
      int i;
      evt_valid <= 1'b1;
      evt_kind <= k;
      evt_module <= m;
      evt_chan <= c;
      evt_flags <= f;
      evt_gateway <= g;
      // Ready judged before the edge; after it the queue count has already moved
      for (i = 0; i < 300; i++) begin
         @(negedge core_clk);
         if (evt_ready === 1'b1)
            break;
      end
      @(posedge core_clk);
      exp_sum = exp_sum | bit_of(k) | 8'h01;
      exp_q.push_back(frame_of(k, m, c, f, g, exp_sum));
   endtask : send_evt

   task automatic drain(string name);
      int i;
      evt_valid <= 1'b0;
      for (i = 0; i < 400 && exp_q.size() != 0; i++)
         @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      chk1("frames left", 1'b1, exp_q.size() == 0);
      $display("test %s done", name);
   endtask : drain

   // Handshake seen at the falling edge, where it stands settled for the next rising edge
   always @(negedge core_clk) begin
      if (evt_ready === 1'b0)
         saw_full <= 1'b1;
      if (resetn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("mismatch frame expected none seen %h", tx_data);
         end else
            chk_frame({11'd128 + {4'h0, node_id}, 4'h8, exp_q.pop_front()}, {tx_id, tx_dlc, tx_data});
      end
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("mismatch run length expected under 20000 seen %0d", cycles);
         give_verdict();
      end
   end

   initial begin
      seed = $urandom(53);
      repeat (4) @(posedge core_clk);
      #1;
      chk8("summary after reset", 8'h00, fault_summary_flags);
      chk1("tx_valid after reset", 1'b0, tx_valid);
      chk1("evt_ready after reset", 1'b1, evt_ready);
      @(posedge core_clk);
      resetn <= 1'b1;
      node_id <= 7'($urandom_range(127, 1));
      @(posedge core_clk);
      for (int k = 0; k < 16; k++)
         send_evt(cef_kind_e'(k), 8'($urandom), 8'($urandom), 8'h01 << $urandom_range(7),
                  $urandom_range(3) == 0);
      drain("all codes");
      stall <= 1'b1;
      for (int n = 0; n < 12; n++)
         send_evt(cef_kind_e'($urandom_range(15)), 8'($urandom), 8'($urandom), 8'h01 << $urandom_range(7), 0);
      drain("stalled burst");
      chk1("queue filled", 1'b1, saw_full);
      stall <= 1'b0;
      clear_mask <= 8'h96;
      @(posedge core_clk);
      clear_mask <= 8'hfe;
      @(posedge core_clk);
      clear_mask <= 8'h00;
      @(posedge core_clk);
      #1;
      exp_sum = 8'h00;
      chk8("summary after clear", exp_sum, fault_summary_flags);
      @(posedge core_clk);
      send_evt(CEF_SYS_LO, 8'h05, 8'h03, 8'h00, 1'b1);
      send_evt(CEF_SYS_HI, 8'h07, 8'h02, 8'h00, 1'b0);
      drain("clear and gateway");
      give_verdict();
   end
endmodule : can_emergency_frame_builder_tb_top

// ---- dv/cef_tx_sink.sv ----
`timescale 1ns/10ps
module cef_tx_sink (
   input  wire logic core_clk,  // System clock
   input  wire logic resetn,    // Sync reset, active low
   input  wire logic stall,     // Take frames slowly
   input  wire logic tx_valid,  // Frame offered
   output logic      tx_ready   // Frame taken
);
   // Slow mode takes roughly one frame in four cycles so the queue backs up
   always_ff @(posedge core_clk) begin
      if (!resetn)
         tx_ready <= 1'b0;
      else
         tx_ready <= stall ? ($urandom_range(3) == 0) : 1'b1;
   end
endmodule : cef_tx_sink

// ---- rtl/can_emergency_frame_builder.sv ----
`timescale 1ns/10ps
`include "cef_cfg.svh"
module can_emergency_frame_builder
   import cef_pkg::*;
#(
   parameter int QDEPTH = 4
) (
   input  wire logic       core_clk,      // System clock, 100 MHz
   input  wire logic       resetn,        // Sync reset, active low
   input  wire logic [6:0] node_id,       // CANopen node identifier
   input  wire logic       evt_valid,     // Error event strobe
   input  cef_kind_e       evt_kind,      // Which error
   input  wire logic [7:0] evt_module,    // Module number
   input  wire logic [7:0] evt_chan,      // Channel number
   input  wire logic [7:0] evt_flags,     // Module-specific flags
   input  wire logic       evt_gateway,   // Fault is the gateway's own
   input  wire logic [7:0] clear_mask,    // Summary bits whose cause is gone
   output logic            evt_ready,     // Event accepted
   output logic [7:0]      fault_summary_flags, // Error summary register
   output logic            tx_valid,      // Frame offered to CAN transmit path
   input  wire logic       tx_ready,      // Transmit path takes frame
   output logic [10:0]     tx_id,         // Frame identifier
   output logic [3:0]      tx_dlc,        // Data length code
   output logic [63:0]     tx_data        // Byte 0 in bits 7:0
);
   cef_evt_if  q_if ();
   cef_event_s in_evt;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND} cef_state_e;
   cef_state_e state_q;

   logic [7:0]  summary_q, summary_d;
   logic [15:0] code;
   logic [7:0]  bit_sel;
   logic        use_mod, use_chan, use_flags;
   logic [7:0]  b3, b4, b5;
   logic        take;

   always_comb begin
      in_evt = '{kind: evt_kind, module_no: evt_module, chan_no: evt_chan, flags: evt_flags};
      if (evt_gateway) begin
         in_evt.module_no = 8'h00;
         in_evt.chan_no   = 8'h00;
      end
   end

   cef_evt_queue #(.DEPTH(QDEPTH)) u_queue (
      .core_clk (core_clk),
      .resetn   (resetn),
      .in_valid (evt_valid),
      .in_evt   (in_evt),
      .in_ready (evt_ready),
      .out      (q_if.src)
   );

   // Decode of the head event into code, summary bit and byte usage
   always_comb begin
      code      = `CEF_EC_NONE;
      bit_sel   = 8'h00;
      use_mod   = 1'b1;
      use_chan  = 1'b1;
      use_flags = 1'b0;
      unique case (q_if.evt.kind)
         CEF_IN_HI:      begin code = `CEF_EC_IN_HI;     bit_sel[`CEF_BIT_CURRENT] = 1'b1; end
         CEF_IN_LO:      begin code = `CEF_EC_IN_LO;     bit_sel[`CEF_BIT_CURRENT] = 1'b1; end
         CEF_OUT_HI:     begin code = `CEF_EC_OUT_HI;    bit_sel[`CEF_BIT_CURRENT] = 1'b1; end
         CEF_OUT_RNG:    begin code = `CEF_EC_OUT_RNG;   bit_sel[`CEF_BIT_CURRENT] = 1'b1; end
         CEF_LOAD_DUMP:  begin code = `CEF_EC_LOAD_DUMP; bit_sel[`CEF_BIT_CURRENT] = 1'b1; end
         CEF_AI_U:       begin code = `CEF_EC_AI_U;      bit_sel[`CEF_BIT_VOLTAGE] = 1'b1; end
         CEF_SYS_HI: begin
            code = `CEF_EC_SYS_HI;
            bit_sel[`CEF_BIT_VOLTAGE] = 1'b1;
            use_mod = 1'b0;
         end
         CEF_SYS_LO:     begin code = `CEF_EC_SYS_LO;    bit_sel[`CEF_BIT_VOLTAGE] = 1'b1; end
         CEF_FIELD_LO:   begin code = `CEF_EC_FIELD_LO;  bit_sel[`CEF_BIT_VOLTAGE] = 1'b1; end
         CEF_MODULE: begin
            code = `CEF_EC_MODULE;
            bit_sel[`CEF_BIT_MANUF] = 1'b1;
            use_flags = 1'b1;
         end
         CEF_LIST_ADAPT, CEF_LIST_INCMP, CEF_LIST_EXP, CEF_LIST_REM: begin
            bit_sel[`CEF_BIT_MANUF] = 1'b1;
            use_chan = 1'b0;
            unique case (q_if.evt.kind)
               CEF_LIST_ADAPT: code = `CEF_EC_LIST_ADAPT;
               CEF_LIST_INCMP: code = `CEF_EC_LIST_INCMP;
               CEF_LIST_EXP:   code = `CEF_EC_LIST_EXP;
               default:        code = `CEF_EC_LIST_REM;
            endcase
         end
         CEF_GUARD: begin
            code = `CEF_EC_GUARD;
            bit_sel[`CEF_BIT_COMM] = 1'b1;
            use_mod = 1'b0;
            use_chan = 1'b0;
         end
         CEF_BUSOFF_OK: begin
            code = `CEF_EC_BUSOFF_OK;
            bit_sel[`CEF_BIT_COMM] = 1'b1;
            use_mod = 1'b0;
            use_chan = 1'b0;
         end
      endcase
   end

   // Unused additional bytes forced to zero
   assign b3 = use_mod   ? q_if.evt.module_no : 8'h00;
   assign b4 = use_chan  ? q_if.evt.chan_no   : 8'h00;
   assign b5 = use_flags ? q_if.evt.flags     : 8'h00;

   assign take       = (state_q == ST_IDLE) && q_if.valid;
   assign q_if.ready = take;

   // Any pending cause keeps the generic bit set; reserved bit stays zero
   always_comb begin
      summary_d = summary_q & ~clear_mask;
      if (take) begin
         summary_d = summary_d | bit_sel;                    // set beats clear
      end
      summary_d[`CEF_BIT_RSVD]    = 1'b0;
      summary_d[`CEF_BIT_GENERIC] = |summary_d[7:1];
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         summary_q <= `CEF_SUMMARY_RST;
      end else begin
         summary_q <= summary_d;
      end
   end
   assign fault_summary_flags = summary_q;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: if (take) state_q <= ST_SEND;
            ST_SEND: if (tx_ready) state_q <= ST_IDLE;
         endcase
      end
   end

   // Frame latched on take; summary byte is the updated value
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tx_id   <= 11'h000;
         tx_dlc  <= 4'h0;
         tx_data <= 64'h0;
      end else if (take) begin
         tx_id   <= `CEF_EMCY_BASE + {4'h0, node_id};
         tx_dlc  <= `CEF_DLC;
         tx_data <= {8'h00, 8'h00, b5, b4, b3,
                     summary_d, code[15:8], code[7:0]};
      end
   end
   assign tx_valid = (state_q == ST_SEND);

   sequence frame_taken_s;
      take;
   endsequence
   sequence frame_offered_s;
      tx_valid && tx_dlc == 4'h8;
   endsequence

   offer_after_a: assert property (@(posedge core_clk) disable iff (!resetn)
      frame_taken_s |=> frame_offered_s)
      else $error("frame not offered after event");
   tail_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
      tx_valid |-> tx_data[63:48] == 16'h0)
      else $error("bytes 6 and 7 not zero");
   id_base_a: assert property (@(posedge core_clk) disable iff (!resetn)
      tx_valid |-> tx_id == 11'h080 + {4'h0, node_id})
      else $error("wrong emergency identifier");
   code_order_a: assert property (@(posedge core_clk) disable iff (!resetn)
      take |=> tx_data[15:0] == $past(code))
      else $error("error code byte order wrong");
   summary_byte_a: assert property (@(posedge core_clk) disable iff (!resetn)
      take |=> tx_data[23:16] == summary_q && (summary_q & $past(bit_sel)) == $past(bit_sel))
      else $error("summary byte or bit wrong");
   generic_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
      summary_q[0] == |summary_q[7:1] && !summary_q[6])
      else $error("generic or reserved bit wrong");
   guard_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (take && q_if.evt.kind inside {CEF_GUARD, CEF_BUSOFF_OK}) |=> tx_data[47:24] == 24'h0)
      else $error("comm frame extra bytes not zero");
   sys_hi_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (take && q_if.evt.kind == CEF_SYS_HI) |=> tx_data[31:24] == 8'h00 && tx_data[15:0] == 16'h3110)
      else $error("supply high frame wrong");
   hold_until_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
      else $error("frame dropped before taken");
endmodule : can_emergency_frame_builder

// ---- rtl/cef_cfg.svh ----
`ifndef CEF_CFG_SVH
`define CEF_CFG_SVH
// Emergency identifier base: 128 plus node identifier
`define CEF_EMCY_BASE     11'h080
`define CEF_DLC           4'h8
// Error summary bit positions
`define CEF_BIT_GENERIC   0
`define CEF_BIT_CURRENT   1
`define CEF_BIT_VOLTAGE   2
`define CEF_BIT_TEMP      3
`define CEF_BIT_COMM      4
`define CEF_BIT_PROFILE   5
`define CEF_BIT_RSVD      6
`define CEF_BIT_MANUF     7
`define CEF_SUMMARY_RST   8'h00
// Error codes
`define CEF_EC_IN_HI      16'h2110
`define CEF_EC_IN_LO      16'h2130
`define CEF_EC_OUT_HI     16'h2310
`define CEF_EC_OUT_RNG    16'h2323
`define CEF_EC_LOAD_DUMP  16'h2330
`define CEF_EC_AI_U       16'h3003
`define CEF_EC_SYS_HI     16'h3110
`define CEF_EC_SYS_LO     16'h3120
`define CEF_EC_FIELD_LO   16'h3320
`define CEF_EC_MODULE     16'h7000
`define CEF_EC_LIST_ADAPT 16'h707a
`define CEF_EC_LIST_INCMP 16'h707d
`define CEF_EC_LIST_EXP   16'h707e
`define CEF_EC_LIST_REM   16'h707f
`define CEF_EC_GUARD      16'h8130
`define CEF_EC_BUSOFF_OK  16'h8140
`define CEF_EC_NONE       16'h0000
`endif

// ---- rtl/cef_evt_if.sv ----
`timescale 1ns/10ps
interface cef_evt_if;
   import cef_pkg::*;
   logic       valid;
   logic       ready;
   cef_event_s evt;
   modport src (output valid, output evt, input ready);
   modport dst (input valid, input evt, output ready);
endinterface : cef_evt_if

// ---- rtl/cef_evt_queue.sv ----
`timescale 1ns/10ps
`include "cef_cfg.svh"
module cef_evt_queue
   import cef_pkg::*;
#(
   parameter int DEPTH = 4
) (
   input  wire logic       core_clk,  // System clock
   input  wire logic       resetn,    // Sync reset, active low
   input  wire logic       in_valid,  // Event offered
   input  cef_event_s      in_evt,    // Event contents
   output logic            in_ready,  // Room for one event
   cef_evt_if.src          out        // Toward frame builder
);
   localparam int AW = $clog2(DEPTH);
   cef_event_s       mem [DEPTH];
   logic [AW-1:0]    wr_q, rd_q;
   logic [AW:0]      cnt_q;
   logic             push, pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out.valid = (cnt_q != '0);
   assign out.evt   = mem[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out.valid && out.ready;

   // Events kept in arrival order
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_q] <= in_evt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   count_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
      cnt_q <= (AW+1)'(DEPTH))
      else $error("event queue count overflow");
   full_refuse_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (cnt_q == (AW+1)'(DEPTH) && !pop) |=> cnt_q == (AW+1)'(DEPTH))
      else $error("queue changed while full");
endmodule : cef_evt_queue

// ---- rtl/cef_pkg.sv ----
package cef_pkg;
   typedef enum logic [3:0] {
      CEF_IN_HI, CEF_IN_LO, CEF_OUT_HI, CEF_OUT_RNG, CEF_LOAD_DUMP,
      CEF_AI_U, CEF_SYS_HI, CEF_SYS_LO, CEF_FIELD_LO, CEF_MODULE,
      CEF_LIST_ADAPT, CEF_LIST_INCMP, CEF_LIST_EXP, CEF_LIST_REM,
      CEF_GUARD, CEF_BUSOFF_OK
   } cef_kind_e;
   typedef struct packed {
      cef_kind_e  kind;
      logic [7:0] module_no;
      logic [7:0] chan_no;
      logic [7:0] flags;
   } cef_event_s;
   typedef logic [7:0] cef_byte_t;
endpackage : cef_pkg
